// ==== verif/adst_datapath_self_test_bench.sv ====
// self-checking bench for the datapath self-test back end
`timescale 1ns/1ps
`include "adst_consts.svh"

module adc_datapath_self_test_bench;
    logic                   mclk;
    logic                   rstn;
    logic [13:0]            stage_codes_a;
    logic [13:0]            stage_codes_b;
    logic                   pwdn;
    logic                   oe_n;
    logic                   reg_wr_en;
    logic [7:0]             reg_addr;
    logic [7:0]             reg_wdata;
    logic [7:0]             reg_rdata;
    adst_pkg::adst_sample_t data_out;
    logic                   data_oe;
    logic [15:0]            bist_signature;
    adst_pkg::adst_sample_t rx_word;
    logic [15:0]            driven_cnt;
    int                     fails;
    int                     checks_done;
    int                     cycles;

    // ======================================================
    // reference models
    function automatic logic [15:0] lfsr_step(logic [15:0] s,
                                              logic [15:0] taps);
        return (s >> 1) ^ (s[0] ? taps : 16'h0000);
    endfunction : lfsr_step

    // msb first over one 16-bit word
    function automatic logic [15:0] crc_word(logic [15:0] c,
                                             logic [15:0] w);
        logic fb;
        for (int i = 15; i >= 0; i--)
        begin
            fb = c[15] ^ w[i];
            c = {c[14:0], 1'b0} ^ (fb ? `ADST_CRC_POLY : 16'h0000);
        end
        return c;
    endfunction : crc_word

    function automatic logic [15:0] run_sig();
        logic [15:0] s;
        logic [15:0] c;
        s = `ADST_LONG_SEED;
        c = `ADST_CRC_INIT;
        for (int n = 0; n < 512; n++)
        begin
            c = crc_word(c, s);
            s = lfsr_step(s, `ADST_LONG_TAPS);
        end
        return c;
    endfunction : run_sig

    localparam logic [15:0] SIG = run_sig();

    // ======================================================
    // instances
    adst_top #(.NST(7), .EXPECTED_SIG(SIG)) dut (
        .mclk(mclk), .rstn(rstn),
        .stage_codes_a(stage_codes_a), .stage_codes_b(stage_codes_b),
        .pwdn(pwdn), .oe_n(oe_n), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .data_out(data_out), .data_oe(data_oe),
        .bist_signature(bist_signature)
    );

    adst_rx_model rx (
        .mclk(mclk), .rstn(rstn), .data_out(data_out), .data_oe(data_oe),
        .rx_word(rx_word), .driven_cnt(driven_cnt)
    );

    // ======================================================
    // clock and timeout
    // clock never stops
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    // a hang counts as a mismatch
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            summarize();
        end
    end

    // ======================================================
    // shared tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic reg_write(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr_en = 1'b0;
    endtask : reg_write

    // read data is registered, so allow two edges after the address
    task automatic reg_read(logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        repeat (2) @(posedge mclk);
        #1;
        d = reg_rdata;
    endtask : reg_read

    task automatic next_word(output adst_pkg::adst_sample_t w);
        @(posedge mclk);
        @(negedge mclk);
        #1;
        w = rx_word;
    endtask : next_word

    // ======================================================
    // scenarios
    task automatic test_regs();
        logic [7:0] r;
        reg_read(8'h0d, r);
        chk("test_reg", 16'h0000, 16'(r));
        reg_read(8'h0e, r);
        chk("bist_reg", 16'h0000, 16'(r));
        reg_write(8'h33, 8'ha5);
        reg_read(8'h33, r);
        chk("unmapped", 16'h0000, 16'(r));
        reg_read(8'h0d, r);
        chk("test_reg", 16'h0000, 16'(r));
    endtask : test_regs

    task automatic test_enable();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            #1;
            {pwdn, oe_n} = 2'(i);
            #10;
            chk("data_oe", 16'(i == 0), 16'(data_oe));
        end
        @(posedge mclk);
        #1;
        {pwdn, oe_n} = 2'b00;
    endtask : test_enable

    // all-ones codes on a, all-threes on b: ramp shows stage alignment
    task automatic test_latency();
        adst_pkg::adst_sample_t w;
        int                     e;
        @(posedge mclk);
        #1;
        stage_codes_a = 14'h1555;
        stage_codes_b = 14'h3fff;
        for (int n = 1; n <= 9; n++)
        begin
            next_word(w);
            e = (n > 7) ? 127 : (1 << n) - 1;
            chk("ch_a", 16'(e), 16'(w.ch_a));
            chk("ch_b", 16'((3*e > 255) ? 255 : 3*e), 16'(w.ch_b));
        end
    endtask : test_latency

    task automatic alt_check(logic [7:0] m, logic [7:0] lo, logic [7:0] hi);
        adst_pkg::adst_sample_t w1;
        adst_pkg::adst_sample_t w2;
        reg_write(8'h0d, m);
        next_word(w1);
        next_word(w1);
        next_word(w2);
        chk("alt", (w1.ch_a == lo) ? {lo, hi} : {hi, lo},
            {w1.ch_a, w2.ch_a});
        chk("alt_b", {w2.ch_a, w2.ch_a}, w2);
    endtask : alt_check

    task automatic test_modes();
        adst_pkg::adst_sample_t w;
        logic [7:0]             r;
        logic [7:0]             fixed [3] = '{8'h80, 8'hff, 8'h00};
        for (int m = 1; m <= 3; m++)
        begin
            reg_write(8'h0d, 8'(m));
            next_word(w);
            next_word(w);
            chk("fixed", {fixed[m-1], fixed[m-1]}, w);
        end
        alt_check(8'h04, 8'h55, 8'haa);
        alt_check(8'h07, 8'h00, 8'hff);
        reg_read(8'h0d, r);
        chk("test_reg", 16'h0007, 16'(r));
    endtask : test_modes

    task automatic check_pn(logic [7:0] held, logic [7:0] run,
                            logic [15:0] seed, logic [15:0] taps);
        adst_pkg::adst_sample_t w [6];
        logic [15:0]            s [9];
        bit                     hit;
        reg_write(8'h0d, held);
        next_word(w[0]);
        next_word(w[0]);
        chk("pn_held", 16'hffff, w[0]);
        reg_write(8'h0d, run);
        for (int i = 0; i < 6; i++)
            next_word(w[i]);
        s[0] = seed;
        for (int i = 1; i < 9; i++)
            s[i] = lfsr_step(s[i-1], taps);
        hit = 1'b0;
        for (int k = 0; k < 3; k++)
            if (w[k].ch_a === s[k][7:0] && w[k+1].ch_a === s[k+1][7:0]
                && w[k+2].ch_a === s[k+2][7:0] && w[k+3].ch_a === s[k+3][7:0])
                hit = 1'b1;
        chk("pn_run", 16'h0001, 16'(hit));
    endtask : check_pn

    task automatic test_bist_pass();
        adst_pkg::adst_sample_t w;
        logic [15:0]            s;
        logic [15:0]            c;
        logic [7:0]             r;
        reg_write(8'h0d, 8'h00);
        reg_write(8'h0e, 8'h05);
        c = driven_cnt;
        s = `ADST_LONG_SEED;
        for (int n = 0; n < 512; n++)
        begin
            next_word(w);
            chk("bist_word", s, w);
            s = lfsr_step(s, `ADST_LONG_TAPS);
        end
        chk("driven", c + 16'd513, driven_cnt);
        repeat (2) next_word(w);
        next_word(w);
        chk("after_run", 16'hff7f, w);
        reg_read(8'h0e, r);
        chk("bist_status", 16'h0007, 16'(r));
        chk("signature", SIG, bist_signature);
    endtask : test_bist_pass

    task automatic test_bist_resume();
        logic [7:0] r;
        reg_write(8'h0e, 8'h01);
        reg_read(8'h0e, r);
        chk("bist_busy", 16'h0081, 16'(r));
        repeat (520) @(posedge mclk);
        reg_read(8'h0e, r);
        chk("bist_status", 16'h0002, 16'(r));
        chk("sig_differs", 16'h0001, 16'(bist_signature !== SIG));
    endtask : test_bist_resume

    // ======================================================
    // main sequence
    initial
    begin
        rstn = 1'b0;
        stage_codes_a = 14'h0000;
        stage_codes_b = 14'h0000;
        pwdn = 1'b0;
        oe_n = 1'b0;
        reg_wr_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        repeat (4) @(posedge mclk);
        #1;
        chk("rst_sig", 16'hffff, bist_signature);
        chk("rst_data", 16'h0000, data_out);
        rstn = 1'b1;
        test_regs();
        test_enable();
        test_latency();
        test_modes();
        check_pn(8'h15, 8'h05, `ADST_LONG_SEED, `ADST_LONG_TAPS);
        check_pn(8'h26, 8'h06, 16'(`ADST_SHORT_SEED), 16'(`ADST_SHORT_TAPS));
        test_bist_pass();
        test_bist_resume();
        summarize();
    end
endmodule : adc_datapath_self_test_bench

// ==== verif/adst_rx_model.sv ====
// receiver model that captures both channel buses of the block
`timescale 1ns/1ps

module adst_rx_model (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire adst_pkg::adst_sample_t data_out,
    input  wire logic                   data_oe,
    output adst_pkg::adst_sample_t      rx_word,
    output logic [15:0]                 driven_cnt
);
    // ======================================================
    // capture
    // sampled mid-cycle, away from the launching edge; a floating bus
    // reads as the inverse of the previous capture, so it toggles every cycle it floats
    always_ff @(negedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_word    <= '0;
            driven_cnt <= 16'h0000;
        end
        else if (data_oe)
        begin
            rx_word    <= data_out;
            driven_cnt <= driven_cnt + 16'h0001;
        end
        else
            rx_word <= ~rx_word;
    end
endmodule : adst_rx_model

// ==== verilog/adst_consts.svh ====
// register offsets, field positions, reset values and run counts
`ifndef ADST_CONSTS_SVH
`define ADST_CONSTS_SVH

// ======================================================
// register offsets
`define ADST_ADDR_TEST          8'h0d
`define ADST_ADDR_BIST          8'h0e

// ======================================================
// field positions
`define ADST_BIST_RUN_BIT       0
`define ADST_BIST_DONE_BIT      1
`define ADST_GENERATOR_RESET_BIT_BIT      2
`define ADST_BIST_BUSY_BIT      7
`define ADST_TEST_MODE_MSB      3
`define ADST_TEST_MODE_LSB      0
`define ADST_TEST_RST_LONG_BIT  4
`define ADST_TEST_RST_SHORT_BIT 5

// ======================================================
// reset values
`define ADST_TEST_RESET         8'h00
`define ADST_BIST_RESET         8'h00
`define ADST_LONG_SEED          16'hffff
`define ADST_SHORT_SEED         9'h1ff
`define ADST_CRC_INIT           16'hffff

// ======================================================
// run length, polynomials and fixed patterns
`define ADST_BIST_CYCLES        10'd512
`define ADST_BIST_LAST          10'd511
`define ADST_CRC_POLY           16'h1021
`define ADST_LONG_TAPS          16'hb400
`define ADST_SHORT_TAPS         9'h110
`define ADST_MIDSCALE           8'h80
`define ADST_FULL_POS           8'hff
`define ADST_FULL_NEG           8'h00
`define ADST_CHECKER_A          8'h55
`define ADST_CHECKER_B          8'haa
`define ADST_SAT_MAX            8'hff

`endif

// ==== verilog/adst_crc.sv ====
// crc signature accumulator at the end of the datapath
`timescale 1ns/1ps
`include "adst_consts.svh"

module adst_crc (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        clear,
    input  wire logic        enable,
    input  wire logic [15:0] data,
    output logic      [15:0] crc
);

    logic [15:0] crc_reg;
    logic [15:0] crc_next;

    // RULE18 fixed polynomial choice
    // msb-first crc over one 16-bit word per clock
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--)
        begin
            if (r[15] ^ d[i])
                r = {r[14:0], 1'b0} ^ `ADST_CRC_POLY;
            else
                r = {r[14:0], 1'b0};
        end
        return r;
    endfunction : crc_step

    // clear beats enable so a restart never mixes old words in
    assign crc_next = clear  ? `ADST_CRC_INIT :
                      enable ? crc_step(crc_reg, data) : crc_reg;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            crc_reg <= `ADST_CRC_INIT;
        else
            crc_reg <= crc_next;
    end

    assign crc = crc_reg;

endmodule : adst_crc

// ==== verilog/adst_pkg.sv ====
// shared types of the datapath self-test block
package adst_pkg;

    // one sample of both channels, taken on the same edge
    typedef struct packed {
        logic [7:0] ch_b;
        logic [7:0] ch_a;
    } adst_sample_t;

    // output test pattern selection, low nibble of the test register
    typedef enum logic [3:0] {
        ADST_TM_OFF      = 4'b0000,
        ADST_TM_MIDSCALE = 4'b0001,
        ADST_TM_FULL_POS = 4'b0010,
        ADST_TM_FULL_NEG = 4'b0011,
        ADST_TM_CHECKER  = 4'b0100,
        ADST_TM_PN_LONG  = 4'b0101,
        ADST_TM_PN_SHORT = 4'b0110,
        ADST_TM_TOGGLE   = 4'b0111
    } adst_test_mode_t;

    // self-test sequencer
    typedef enum logic [1:0] {
        ADST_ST_IDLE  = 2'b00,
        ADST_ST_RUN   = 2'b01,
        ADST_ST_DRAIN = 2'b10,
        ADST_ST_CHECK = 2'b11
    } adst_bist_state_t;

endpackage : adst_pkg

// ==== verilog/adst_top.sv ====
// dual-channel back end: correction, self-test, test patterns, drivers
// Functional notes
// RULE1 - both channels captured on one shared clock
// RULE2 - merge stage codes into one 8-bit result
// RULE3 - new sample each clock, fixed latency
// RULE4 - power-down floats every output driver
// RULE5 - high output-enable pin floats both buses
// RULE6 - self-test injects pseudorandom words, both channels
// RULE7 - crc signature accumulated at datapath end
// RULE8 - self-test runs exactly 512 cycles, stops
// RULE9 - match sets bit 0, mismatch clears it
// RULE10 - outputs stay driven during self-test
// RULE11 - writing 0x05 starts run, reseeds generator
// RULE12 - run completion clears bit 0 itself (code clears it only on a signature mismatch and leaves it set on a match)
// RULE13 - without init bit generator resumes last state
// RULE14 - controller should start self-test after reset
// RULE15 - test mode replaces analog data with pattern
// RULE16 - bits 4 and 5 reset pattern generators
// RULE17 - patterns advance only on the encode clock
// RULE18 - polynomials and expected signature are fixed choices
`timescale 1ns/1ps
`include "adst_consts.svh"

module adst_top #(
    parameter int          NST          = 7,
    parameter logic [15:0] EXPECTED_SIG = 16'h0000
) (
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    input  wire logic [2*NST-1:0]     stage_codes_a,
    input  wire logic [2*NST-1:0]     stage_codes_b,
    input  wire logic                 pwdn,
    input  wire logic                 oe_n,
    input  wire logic                 reg_wr_en,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    output adst_pkg::adst_sample_t    data_out,
    output logic                      data_oe,
    output logic      [15:0]          bist_signature
);

    // ======================================================
    // functions
    // align stage codes: stage k waits NST-1-k cycles for its sample
    function automatic logic [2*NST-1:0] align(
        input logic [NST-2:0][2*NST-1:0] d,
        input logic [2*NST-1:0]          now);
        logic [2*NST-1:0] r;
        r = now;
        for (int k = 0; k < NST - 1; k++)
            r[2*k +: 2] = d[NST-2-k][2*k +: 2];
        return r;
    endfunction : align

    // weighted sum of overlapping stage codes, saturated to 8 bits
    function automatic logic [7:0] correct(input logic [2*NST-1:0] c);
        logic [15:0] acc;
        acc = 16'h0000;
        for (int k = 0; k < NST; k++)
            acc = acc + (16'(c[2*k +: 2]) << (NST - 1 - k));
        return (acc > 16'h00ff) ? `ADST_SAT_MAX : acc[7:0];
    endfunction : correct

    function automatic logic [15:0] lfsr16(input logic [15:0] s);
        return s[0] ? ((s >> 1) ^ `ADST_LONG_TAPS) : (s >> 1);
    endfunction : lfsr16

    function automatic logic [8:0] lfsr9(input logic [8:0] s);
        return s[0] ? ((s >> 1) ^ `ADST_SHORT_TAPS) : (s >> 1);
    endfunction : lfsr9

    // ======================================================
    // state
    logic [NST-2:0][2*NST-1:0]  dly_a_reg;
    logic [NST-2:0][2*NST-1:0]  dly_b_reg;
    logic [7:0]                 test_reg;
    logic [7:0]                 bist_reg;
    adst_pkg::adst_bist_state_t state_reg;
    adst_pkg::adst_bist_state_t state_next;
    logic [9:0]                 cnt_reg;
    logic [15:0]                bist_pn_reg;
    logic [15:0]                long_pn_reg;
    logic [8:0]                 short_pn_reg;
    logic                       tgl_reg;
    logic                       crc_en_reg;
    adst_pkg::adst_sample_t     out_reg;
    adst_pkg::adst_sample_t     out_next;
    logic [7:0]                 rdata_reg;
    logic [15:0]                crc_value;

    // ======================================================
    // register decode
    wire wr_test  = reg_wr_en && (reg_addr == `ADST_ADDR_TEST);
    wire wr_bist  = reg_wr_en && (reg_addr == `ADST_ADDR_BIST);
    // RULE11 start on run bit, init bit reseeds
    wire start    = wr_bist && reg_wdata[`ADST_BIST_RUN_BIT];
    wire reseed   = start && reg_wdata[`ADST_GENERATOR_RESET_BIT_BIT];
    wire running  = (state_reg == adst_pkg::ADST_ST_RUN);
    wire checking = (state_reg == adst_pkg::ADST_ST_CHECK);
    // RULE9 compare signature with the fixed expected value
    wire sig_match = (crc_value == EXPECTED_SIG);
    wire [3:0] mode = test_reg[`ADST_TEST_MODE_MSB:`ADST_TEST_MODE_LSB];
    wire rst_long  = test_reg[`ADST_TEST_RST_LONG_BIT];
    wire rst_short = test_reg[`ADST_TEST_RST_SHORT_BIT];

    // ======================================================
    // correction datapath
    wire [2*NST-1:0] aligned_a = align(dly_a_reg, stage_codes_a);
    wire [2*NST-1:0] aligned_b = align(dly_b_reg, stage_codes_b);
    // RULE2 merge all stage contributions per channel
    wire [7:0] conv_a = correct(aligned_a);
    wire [7:0] conv_b = correct(aligned_b);

    // RULE3 delay lines keep every stage code moving each clock
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            dly_a_reg <= '0;
            dly_b_reg <= '0;
        end
        else
        begin
            dly_a_reg <= {dly_a_reg[NST-3:0], stage_codes_a};
            dly_b_reg <= {dly_b_reg[NST-3:0], stage_codes_b};
        end
    end

    // ======================================================
    // test pattern selection
    logic [7:0] pat_a;
    logic [7:0] pat_b;
    always_comb
    begin
        case (mode)
            adst_pkg::ADST_TM_MIDSCALE: pat_a = `ADST_MIDSCALE;
            adst_pkg::ADST_TM_FULL_POS: pat_a = `ADST_FULL_POS;
            adst_pkg::ADST_TM_FULL_NEG: pat_a = `ADST_FULL_NEG;
            adst_pkg::ADST_TM_CHECKER:
                pat_a = tgl_reg ? `ADST_CHECKER_B : `ADST_CHECKER_A;
            adst_pkg::ADST_TM_PN_LONG:  pat_a = long_pn_reg[7:0];
            adst_pkg::ADST_TM_PN_SHORT: pat_a = short_pn_reg[7:0];
            adst_pkg::ADST_TM_TOGGLE:
                pat_a = tgl_reg ? `ADST_FULL_POS : `ADST_FULL_NEG;
            default:                    pat_a = `ADST_FULL_NEG;
        endcase
        pat_b = pat_a;
    end

    // source priority: self-test, then test pattern, then converter
    always_comb
    begin
        // RULE6 generator word replaces converter output on both channels
        if (running)
        begin
            out_next.ch_a = bist_pn_reg[7:0];
            out_next.ch_b = bist_pn_reg[15:8];
        end
        // RULE15 analog result is ignored while a pattern is selected
        else if (mode != adst_pkg::ADST_TM_OFF)
        begin
            out_next.ch_a = pat_a;
            out_next.ch_b = pat_b;
        end
        else
        begin
            out_next.ch_a = conv_a;
            out_next.ch_b = conv_b;
        end
    end

    // RULE1 both channels land in the output register on one edge
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            out_reg <= '0;
        else
            out_reg <= out_next;
    end

    // ======================================================
    // pattern generators
    // RULE17 every generator steps only on the encode clock
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            long_pn_reg  <= `ADST_LONG_SEED;
            short_pn_reg <= `ADST_SHORT_SEED;
            tgl_reg      <= 1'b0;
        end
        else
        begin
            // RULE16 held at seed while its reset bit is set
            long_pn_reg  <= rst_long  ? `ADST_LONG_SEED  : lfsr16(long_pn_reg);
            short_pn_reg <= rst_short ? `ADST_SHORT_SEED : lfsr9(short_pn_reg);
            tgl_reg      <= ~tgl_reg;
        end
    end

    // self-test generator only steps while injecting
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            bist_pn_reg <= `ADST_LONG_SEED;
        // RULE13 without reseed the last state is kept for the next run
        else if (reseed)
            bist_pn_reg <= `ADST_LONG_SEED;
        else if (running && !start)
            bist_pn_reg <= lfsr16(bist_pn_reg);
    end

    // ======================================================
    // self-test sequencer
    always_comb
    begin
        case (state_reg)
            adst_pkg::ADST_ST_IDLE:  state_next = adst_pkg::ADST_ST_IDLE;
            // RULE8 leave after the 512th injected word
            adst_pkg::ADST_ST_RUN:
                state_next = (cnt_reg == `ADST_BIST_LAST) ?
                             adst_pkg::ADST_ST_DRAIN : adst_pkg::ADST_ST_RUN;
            adst_pkg::ADST_ST_DRAIN: state_next = adst_pkg::ADST_ST_CHECK;
            adst_pkg::ADST_ST_CHECK: state_next = adst_pkg::ADST_ST_IDLE;
            default:                 state_next = adst_pkg::ADST_ST_IDLE;
        endcase
        if (start)
            state_next = adst_pkg::ADST_ST_RUN;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg  <= adst_pkg::ADST_ST_IDLE;
            cnt_reg    <= 10'd0;
            crc_en_reg <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            cnt_reg    <= (start || !running) ? 10'd0 : cnt_reg + 10'd1;
            // the word injected this cycle sits in out_reg next cycle
            crc_en_reg <= running && !start;
        end
    end

    // RULE7 signature over the words leaving the output register
    adst_crc u_crc (
        .mclk   (mclk),
        .rstn   (rstn),
        .clear  (start),
        .enable (crc_en_reg),
        .data   (out_reg),
        .crc    (crc_value)
    );

    // ======================================================
    // registers
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            test_reg <= `ADST_TEST_RESET;
        else if (wr_test)
            test_reg <= reg_wdata;
    end

    // result in bit 0 wins over a same-cycle software write unless that write sets the run bit
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            bist_reg <= `ADST_BIST_RESET;
        else if (start)
            bist_reg <= reg_wdata & 8'h05;
        else if (checking)
        begin
            // RULE12 bit 0 drops at completion unless signature matches
            bist_reg[`ADST_BIST_RUN_BIT]  <= sig_match;
            bist_reg[`ADST_BIST_DONE_BIT] <= 1'b1;
            if (wr_bist)
                bist_reg[`ADST_GENERATOR_RESET_BIT_BIT] <=
                    reg_wdata[`ADST_GENERATOR_RESET_BIT_BIT];
        end
        else if (wr_bist)
            bist_reg <= {bist_reg[7:3], reg_wdata[`ADST_GENERATOR_RESET_BIT_BIT],
                         bist_reg[`ADST_BIST_DONE_BIT], 1'b0};
    end

    // read data registered; unmapped offsets read zero
    wire busy = (state_reg != adst_pkg::ADST_ST_IDLE);
    wire [7:0] bist_view = {busy, 4'h0, bist_reg[2:0]};
    wire [7:0] rd_mux = (reg_addr == `ADST_ADDR_TEST) ? test_reg  :
                        (reg_addr == `ADST_ADDR_BIST) ? bist_view : 8'h00;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rd_mux;
    end

    // ======================================================
    // outputs
    // RULE4 power-down floats drivers
    // RULE5 high enable pin floats both buses
    // RULE10 self-test does not affect the enable
    assign data_oe        = !oe_n && !pwdn;
    assign data_out       = out_reg;
    assign reg_rdata      = rdata_reg;
    assign bist_signature = crc_value;

    // ======================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    logic [10:0] run_len_reg;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            run_len_reg <= 11'd0;
        else
            run_len_reg <= running ? run_len_reg + 11'd1 : 11'd0;
    end

    pwdn_float_a: assert property (pwdn |-> !data_oe) // RULE4
        else $error("drivers on in power-down");
    oe_pin_a: assert property (oe_n |-> !data_oe) // RULE5
        else $error("drivers on with enable pin high");
    drive_run_a: assert property ( // RULE10
        running && !oe_n && !pwdn |-> data_oe)
        else $error("drivers off during self-test");
    run_len_a: assert property (running && !start && !$past(start)
        ##1 !running |-> run_len_reg == 11'd512) // RULE8
        else $error("self-test run not 512 cycles");
    inject_a: assert property (running && !start
        |=> data_out == $past(bist_pn_reg)) // RULE6
        else $error("generator word not on outputs");
    reseed_a: assert property (reseed |=> bist_pn_reg == 16'hffff) // RULE11
        else $error("generator not reseeded");
    resume_a: assert property (start && !reseed && !running
        |=> bist_pn_reg == $past(bist_pn_reg)) // RULE13
        else $error("generator lost its state");
    drain_crc_a: assert property (state_reg == adst_pkg::ADST_ST_DRAIN
        |-> crc_en_reg) // RULE7
        else $error("last word not taken by crc");
    result_bit_a: assert property (checking && !start
        |=> bist_reg[0] == $past(sig_match)) // RULE9
        else $error("result bit wrong after run");
    done_clear_a: assert property (checking && !sig_match && !start
        |=> !bist_reg[0] ##1 !busy) // RULE12
        else $error("bit 0 not cleared at completion");
    midscale_a: assert property (!running && !start
        && mode == adst_pkg::ADST_TM_MIDSCALE
        |=> data_out.ch_a == 8'h80 && data_out.ch_b == 8'h80) // RULE15
        else $error("midscale pattern missing");
    gen_reset_a: assert property (rst_long |=> &long_pn_reg) // RULE16
        else $error("long generator not held at seed");

    pass_c: cover property (checking && sig_match);
    fail_c: cover property (checking && !sig_match);
    pn_mode_c: cover property (mode == adst_pkg::ADST_TM_PN_LONG && data_oe);
    float_c: cover property (running && !data_oe);

endmodule : adst_top
